// file: hw/dct_channel.sv
// one dma channel: request start, config check, read/write sequencing, status
`timescale 1ns/1ns
// Functional notes
// - incrementing address advances by 1, 2, 4 or 16 per operand size
// - no-count address register stays unchanged after each operand
// - byte count drops by the transferred operand size each transfer
// - single-address mode uses only the source address, never destination
// - internal request: start pulse requests the bus at once
// - external request: no bus request before the request line rises
// - control field changes take effect at once, even while active
// - external request starts only when idle; cycle-steal gives one transfer
// - accesses from external request are marked dma and external
// - auto-align picks source if its size is larger or equal, else destination
// - aligned register always increments; only the other side is checked
// - count above 16: small accesses until aligned, then programmed size
// - under 16 bytes left: size taken from remaining count
// - destination writes use largest size address allows, capped by its size
// - boundary skipped under auto-align keeps the bus request asserted
// - bandwidth field picks block size; bus request drops at boundary access
// - bandwidth zero holds request to count zero and flags priority
// - bus error sets read or write error flag and halts; data dropped
// - interrupt follows done when enabled; writing done clears flags
// - count zero sets done, otherwise another read/write transfer starts unless cycle-steal is set
// - size/address/count mismatch: no transfer, config error flag set
module dct_channel
  import dct_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic [dct_pkg::ADDR_W-1:0] wr_data_i,
  input wire logic src_addr_wr_i,
  input wire logic dst_addr_wr_i,
  input wire logic count_wr_i,
  input wire logic [1:0] source_size_field_i,
  input wire logic [1:0] dest_size_field_i,
  input wire logic source_increment_bit_i,
  input wire logic dest_increment_bit_i,
  input wire logic external_request_enable_i,
  input wire logic cycle_steal_i,
  input wire logic auto_align_bit_i,
  input wire logic [2:0] bandwidth_limit_field_i,
  input wire logic single_address_bit_i,
  input wire logic single_read_i,
  input wire logic int_enable_i,
  input wire logic start_i,
  input wire logic done_wr_i,
  input wire logic ext_transfer_request_i,
  input wire logic bus_grant_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [dct_pkg::DATA_W-1:0] rdata_i,
  output logic [dct_pkg::ADDR_W-1:0] src_addr_o,
  output logic [dct_pkg::ADDR_W-1:0] dst_addr_o,
  output logic [dct_pkg::CNT_W-1:0] count_o,
  output logic busy_o,
  output logic done_o,
  output logic read_error_flag_o,
  output logic write_error_flag_o,
  output logic cfg_error_o,
  output logic irq_o,
  output logic priority_o,
  output logic bus_req_o,
  output logic valid_o,
  output logic [dct_pkg::ADDR_W-1:0] addr_o,
  output logic rw_o,
  output logic [1:0] size_o,
  output logic [dct_pkg::DATA_W-1:0] wdata_o,
  output logic dma_cycle_o,
  output logic ext_cycle_o
);
  import dct_pkg::*;

  dct_state_t st;
  logic [ADDR_W-1:0] source_address_reg, dest_address_reg;
  logic [CNT_W-1:0] byte_count_reg;
  logic [4:0] rd_left, wr_left, acc_sz;
  logic acc_act, ext_origin, rel_hold;
  logic done, rd_err, wr_err, cfg_err;
  logic [DATA_W-1:0] hold;

  logic [4:0] sb, db, rem16, rsz, wsz, cur_sz, unit;
  logic src_al, dst_al, cfg_bad, acc_ok, acc_err, launch, xfer_end;
  logic ev_cfg, ev_done, go;
  logic [CNT_W-1:0] nb, nb_launch, bw_mask;

  // ----------------------------------------
  // sizing and checks, all from live control inputs
  // ----------------------------------------
  always_comb begin
    sb = dct_bytes(source_size_field_i);
    db = dct_bytes(dest_size_field_i);
    src_al = auto_align_bit_i && (sb >= db);
    dst_al = auto_align_bit_i && !src_al && !single_address_bit_i;
    rem16 = (byte_count_reg >= {19'h0, REM_MAX}) ? REM_MAX : byte_count_reg[4:0];
    if (auto_align_bit_i) begin
      unit = src_al ? dct_fit(source_address_reg[3:0], sb, rem16)
                    : dct_fit(dest_address_reg[3:0], db, rem16);
      rsz = dct_fit(source_address_reg[3:0], sb, rd_left);
      wsz = dct_fit(dest_address_reg[3:0], db, wr_left);
    end else begin
      unit = (single_address_bit_i || sb >= db) ? sb : db;
      rsz = sb;
      wsz = db;
    end
    cur_sz = (st == ST_WRITE) ? wsz : rsz;
    // aligned side is exempt from the checks
    cfg_bad = 1'b0;
    if (!src_al && (source_address_reg[4:0] & (sb - B_BYTE)) != 5'h00) cfg_bad = 1'b1;
    if (!single_address_bit_i && !dst_al &&
        (dest_address_reg[4:0] & (db - B_BYTE)) != 5'h00) cfg_bad = 1'b1;
    if (auto_align_bit_i) begin
      if (src_al && !single_address_bit_i &&
          (byte_count_reg[4:0] & (db - B_BYTE)) != 5'h00) cfg_bad = 1'b1;
      if (dst_al && (byte_count_reg[4:0] & (sb - B_BYTE)) != 5'h00) cfg_bad = 1'b1;
    end else if ((byte_count_reg[4:0] & (sb - B_BYTE)) != 5'h00 &&
                 (single_address_bit_i ||
                  (byte_count_reg[4:0] & (db - B_BYTE)) != 5'h00)) begin
      cfg_bad = 1'b1;
    end
  end

  // ----------------------------------------
  // events
  // ----------------------------------------
  always_comb begin
    go = external_request_enable_i ? ext_transfer_request_i : start_i;
    acc_ok = acc_act && ack_i && !err_i;
    acc_err = acc_act && err_i;
    launch = (st == ST_READ || st == ST_WRITE) && !acc_act && bus_grant_i && bus_req_o;
    nb = byte_count_reg - {19'h0, acc_sz};
    nb_launch = byte_count_reg - {19'h0, cur_sz};
    bw_mask = CNT_W'((CNT_ONE << ({1'b0, bandwidth_limit_field_i} + BW_SHIFT)) - CNT_ONE);
    xfer_end = acc_ok && ((st == ST_READ && single_address_bit_i) ||
                          (st == ST_WRITE && wr_left == acc_sz));
    ev_cfg = (st == ST_CHECK) && cfg_bad;
    ev_done = ev_cfg || ((st == ST_CHECK) && byte_count_reg == CNT_RST) ||
              acc_err || (xfer_end && nb == CNT_RST);
  end

  // ----------------------------------------
  // channel sequencer and address/count registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st <= ST_IDLE;
      source_address_reg <= ADDR_RST;
      dest_address_reg <= ADDR_RST;
      byte_count_reg <= CNT_RST;
      rd_left <= 5'h00;
      wr_left <= 5'h00;
      acc_sz <= 5'h00;
      acc_act <= 1'b0;
      ext_origin <= 1'b0;
      hold <= 32'h0000_0000;
    end else begin
      if (launch) begin
        acc_act <= 1'b1;
        acc_sz <= cur_sz; // latched so a mid-access field change stays safe
      end
      if (acc_ok || acc_err) acc_act <= 1'b0;
      case (st)
        ST_IDLE: begin
          if (go && !done_wr_i) begin
            ext_origin <= external_request_enable_i;
            st <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (ev_done) begin
            st <= ST_IDLE;
          end else begin
            rd_left <= unit;
            wr_left <= unit;
            st <= ST_READ;
          end
        end
        ST_READ: begin
          if (acc_err) begin
            st <= ST_IDLE;
          end else if (acc_ok) begin
            hold <= rdata_i;
            rd_left <= rd_left - acc_sz;
            if (source_increment_bit_i || src_al)
              source_address_reg <= source_address_reg + {27'h0, acc_sz};
            if (single_address_bit_i) begin
              byte_count_reg <= nb;
            end else if (rd_left == acc_sz) begin
              st <= ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          if (acc_err) begin
            hold <= 32'h0000_0000;
            st <= ST_IDLE;
          end else if (acc_ok) begin
            wr_left <= wr_left - acc_sz;
            byte_count_reg <= nb;
            if (dest_increment_bit_i || dst_al)
              dest_address_reg <= dest_address_reg + {27'h0, acc_sz};
          end
        end
        default: st <= ST_IDLE;
      endcase
      if (xfer_end) begin
        if (nb == CNT_RST || cycle_steal_i) st <= ST_IDLE;
        else st <= ST_CHECK;
      end
      if (done_wr_i) begin
        st <= ST_IDLE;
        acc_act <= 1'b0;
      end
      // software writes win over same-cycle hardware updates
      if (src_addr_wr_i) source_address_reg <= wr_data_i;
      if (dst_addr_wr_i) dest_address_reg <= wr_data_i;
      if (count_wr_i) byte_count_reg <= wr_data_i[CNT_W-1:0];
    end
  end

  // ----------------------------------------
  // status flags; a set beats a same-cycle clear
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      done <= 1'b0;
      rd_err <= 1'b0;
      wr_err <= 1'b0;
      cfg_err <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      done <= ev_done || (done && !done_wr_i);
      rd_err <= (acc_err && st == ST_READ) || (rd_err && !done_wr_i);
      wr_err <= (acc_err && st == ST_WRITE) || (wr_err && !done_wr_i);
      cfg_err <= ev_cfg || (cfg_err && !done_wr_i);
      irq_o <= int_enable_i && (ev_done || (done && !done_wr_i));
    end
  end

  // ----------------------------------------
  // bus master signals
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      bus_req_o <= 1'b0;
      rel_hold <= 1'b0;
      valid_o <= 1'b0;
      addr_o <= ADDR_RST;
      rw_o <= 1'b1;
      size_o <= SZ_LONG;
      wdata_o <= 32'h0000_0000;
      dma_cycle_o <= 1'b0;
      ext_cycle_o <= 1'b0;
      priority_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      valid_o <= launch;
      // an unaligned step past the boundary never matches, so the request stays up
      if (launch && bandwidth_limit_field_i != 3'h0 && nb_launch != CNT_RST &&
          (nb_launch & bw_mask) == CNT_RST &&
          (single_address_bit_i || (st == ST_WRITE && wr_left == wsz)))
        rel_hold <= 1'b1;
      else if (acc_ok || acc_err || done_wr_i)
        rel_hold <= 1'b0;
      // held through the check cycle too, so an unlimited channel never lets go early
      bus_req_o <= (st != ST_IDLE) && !done_wr_i && !ev_done &&
                   !rel_hold && !(xfer_end && cycle_steal_i);
      if (launch) begin
        addr_o <= (st == ST_WRITE) ? dest_address_reg : source_address_reg;
        rw_o <= (st == ST_WRITE) ? 1'b0 : (!single_address_bit_i || single_read_i);
        size_o <= dct_code(cur_sz);
        wdata_o <= hold;
        dma_cycle_o <= 1'b1;
        ext_cycle_o <= ext_origin;
      end else if (acc_ok || acc_err || done_wr_i) begin
        dma_cycle_o <= 1'b0;
        ext_cycle_o <= 1'b0;
      end
      priority_o <= (st != ST_IDLE) && bandwidth_limit_field_i == 3'h0;
      busy_o <= (st != ST_IDLE);
    end
  end

  assign src_addr_o = source_address_reg;
  assign dst_addr_o = dest_address_reg;
  assign count_o = byte_count_reg;
  assign done_o = done;
  assign read_error_flag_o = rd_err;
  assign write_error_flag_o = wr_err;
  assign cfg_error_o = cfg_err;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  src_step_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (acc_ok && st == ST_READ && source_increment_bit_i && !src_addr_wr_i && !done_wr_i)
    |=> source_address_reg == $past(source_address_reg) + {27'h0, $past(acc_sz)})
    else $error("source address step wrong");
  src_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (st == ST_READ && !source_increment_bit_i && !src_al && !src_addr_wr_i)
    |=> $stable(source_address_reg))
    else $error("no-count source address moved");
  count_dec_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (acc_ok && st == ST_WRITE && !count_wr_i && !done_wr_i)
    |=> byte_count_reg == $past(byte_count_reg) - {19'h0, $past(acc_sz)})
    else $error("byte count not reduced by size");
  single_src_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (launch && single_address_bit_i) |=> addr_o == $past(source_address_reg) && valid_o)
    else $error("single access not on source address");
  int_start_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (st == ST_IDLE && !external_request_enable_i && start_i && !done_wr_i)
    |=> st == ST_CHECK)
    else $error("start pulse ignored");
  ext_wait_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (st == ST_IDLE && external_request_enable_i && !ext_transfer_request_i)
    |=> st == ST_IDLE ##1 !bus_req_o)
    else $error("bus requested without external request");
  ext_mark_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    valid_o |-> dma_cycle_o && (ext_cycle_o == ext_origin))
    else $error("access markers wrong");
  err_halt_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (acc_err && st == ST_READ && !done_wr_i) |=> rd_err && done && st == ST_IDLE)
    else $error("read error not flagged");
  done_clr_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (done_wr_i && !ev_done) |=> !done && !rd_err && !wr_err && !cfg_err ##1 !irq_o)
    else $error("done write did not clear");
  cfg_stop_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ev_cfg |=> cfg_err && st == ST_IDLE && !valid_o)
    else $error("config error not handled");
  prio_flag_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (st == ST_READ && bandwidth_limit_field_i == 3'h0) |=> priority_o)
    else $error("priority flag missing");
endmodule

// file: hw/dct_pkg.sv
// constants, types and helpers shared by the dma channel
package dct_pkg;
  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int ADDR_W = 32;
  localparam int CNT_W = 24;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
  localparam logic [3:0] BW_SHIFT = 4'h8; // block = 2^(field+8) bytes
  localparam logic [4:0] REM_MAX = 5'h10;
  // ----------------------------------------
  // operand size codes and byte counts
  // ----------------------------------------
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LINE = 2'h3;
  localparam logic [4:0] B_BYTE = 5'h01;
  localparam logic [4:0] B_WORD = 5'h02;
  localparam logic [4:0] B_LONG = 5'h04;
  localparam logic [4:0] B_LINE = 5'h10;
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_READ, ST_WRITE} dct_state_t;

  function automatic logic [4:0] dct_bytes(input logic [1:0] code);
    case (code)
      SZ_BYTE: dct_bytes = B_BYTE;
      SZ_WORD: dct_bytes = B_WORD;
      SZ_LINE: dct_bytes = B_LINE;
      default: dct_bytes = B_LONG;
    endcase
  endfunction

  function automatic logic [1:0] dct_code(input logic [4:0] b);
    case (b)
      B_BYTE: dct_code = SZ_BYTE;
      B_WORD: dct_code = SZ_WORD;
      B_LINE: dct_code = SZ_LINE;
      default: dct_code = SZ_LONG;
    endcase
  endfunction

  // largest size allowed by address, size limit and bytes left
  function automatic logic [4:0] dct_fit(input logic [3:0] a, input logic [4:0] lim,
                                         input logic [4:0] left);
    if (lim >= B_LINE && left >= B_LINE && a == 4'h0) dct_fit = B_LINE;
    else if (lim >= B_LONG && left >= B_LONG && a[1:0] == 2'h0) dct_fit = B_LONG;
    else if (lim >= B_WORD && left >= B_WORD && a[0] == 1'b0) dct_fit = B_WORD;
    else dct_fit = B_BYTE;
  endfunction
endpackage

// file: tb/dct_bus_model.sv
// bus arbiter and memory model on the far side of the dma channel
`timescale 1ns/1ns
module dct_bus_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic bus_req_i,
  input wire logic valid_i,
  input wire logic rw_i,
  input wire logic [31:0] addr_i,
  input wire logic [1:0] lat_i,
  input wire logic err_rd_i,
  input wire logic err_wr_i,
  output logic grant_o,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] rdata_o
);
  logic open_q;
  logic rw_q;
  logic [1:0] wait_q;
  logic [31:0] addr_q;
  // ----------------------------------------
  // arbitration and answers
  // ----------------------------------------
  // grant lags the request by a cycle and drops a cycle after the request does
  always_ff @(posedge sys_clk_i) begin
    grant_o <= nrst_i & bus_req_i;
  end
  // read data toggles outside answers so a stale value is never mistaken for data
  always_ff @(posedge sys_clk_i) begin
    ack_o <= 1'h0;
    err_o <= 1'h0;
    rdata_o <= ~rdata_o;
    if (!nrst_i) begin
      open_q <= 1'h0;
      wait_q <= 2'h0;
      rdata_o <= 32'h5a5a_a5a5;
    end else if (valid_i) begin
      open_q <= 1'h1;
      wait_q <= lat_i;
      rw_q <= rw_i;
      addr_q <= addr_i;
    end else if (open_q && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (open_q) begin
      open_q <= 1'h0;
      err_o <= rw_q ? err_rd_i : err_wr_i;
      ack_o <= rw_q ? !err_rd_i : !err_wr_i;
      rdata_o <= addr_q ^ 32'hc3c3_0000;
    end
  end
endmodule

// file: tb/dma_channel_transfer_bench.sv
// self-checking bench for the dma channel against the bus model
`timescale 1ns/1ns
module dma_channel_transfer_bench;
  import dct_pkg::*;
  typedef struct packed {
    logic [1:0] ss;
    logic [1:0] ds;
    logic si;
    logic di;
    logic [23:0] cnt;
    logic [7:0] rd;
    logic [7:0] wr;
  } dct_row_t;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk = 1'h0, nrst = 1'h0, saw = 1'h0, daw = 1'h0, cw = 1'h0, st = 1'h0, dw = 1'h0;
  logic si = 1'h0, di = 1'h0, ext = 1'h0, cs = 1'h0, aa = 1'h0, sa = 1'h0, srd = 1'h0;
  logic ie = 1'h0, xreq = 1'h0, erd = 1'h0, ewr = 1'h0, prio_seen, prev_req = 1'h0;
  logic [1:0] ss = 2'h0, ds = 2'h0, lat = 2'h0, size;
  logic [2:0] bw = 3'h0;
  logic [31:0] wdat = 32'h0, src_a, dst_a, addr, rdata, wd, raddr;
  logic [23:0] count;
  logic busy, done, rd_err, wr_err, cfg_err, irq, prio, bus_req, valid, rw;
  logic dma_cyc, ext_cyc, grant, ack, err;
  int fail_count = 0, n_compared = 0, n_rd, n_wr, n_ext, n_drop, n_brd;
  dct_row_t rows [6];

  dct_channel dct_channel_i (.sys_clk_i(clk), .nrst_i(nrst), .wr_data_i(wdat),
    .src_addr_wr_i(saw), .dst_addr_wr_i(daw), .count_wr_i(cw), .source_size_field_i(ss),
    .dest_size_field_i(ds), .source_increment_bit_i(si), .dest_increment_bit_i(di),
    .external_request_enable_i(ext), .cycle_steal_i(cs), .auto_align_bit_i(aa),
    .bandwidth_limit_field_i(bw), .single_address_bit_i(sa), .single_read_i(srd),
    .int_enable_i(ie), .start_i(st), .done_wr_i(dw), .ext_transfer_request_i(xreq),
    .bus_grant_i(grant), .ack_i(ack), .err_i(err), .rdata_i(rdata), .src_addr_o(src_a),
    .dst_addr_o(dst_a), .count_o(count), .busy_o(busy), .done_o(done),
    .read_error_flag_o(rd_err), .write_error_flag_o(wr_err), .cfg_error_o(cfg_err),
    .irq_o(irq), .priority_o(prio), .bus_req_o(bus_req), .valid_o(valid), .addr_o(addr),
    .rw_o(rw), .size_o(size), .wdata_o(wd), .dma_cycle_o(dma_cyc), .ext_cycle_o(ext_cyc));
  dct_bus_model dct_bus_model_i (.sys_clk_i(clk), .nrst_i(nrst), .bus_req_i(bus_req),
    .valid_i(valid), .rw_i(rw), .addr_i(addr), .lat_i(lat), .err_rd_i(erd),
    .err_wr_i(ewr), .grant_o(grant), .ack_o(ack), .err_o(err), .rdata_o(rdata));

  always #5 clk = ~clk;
  // accesses and request drops are counted from what the channel drives
  always @(posedge clk) begin
    if (valid === 1'h1) begin
      n_rd += rw;
      n_wr += !rw;
      n_ext += dma_cyc & ext_cyc;
      n_brd += rw & (size == SZ_BYTE);
      // a dual write carries the word the model returned for the last read
      if (rw) raddr = addr;
      else if (!sa) check(wd, raddr ^ 32'hc3c3_0000);
    end
    // the last write's own drop is left out: count is 4 or less there
    if (prev_req && !bus_req && count > 24'h4) n_drop++;
    prio_seen |= prio;
    prev_req = bus_req;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic load(input logic [31:0] v, input int which);
    @(negedge clk);
    wdat = v;
    {saw, daw, cw} = {which == 0, which == 1, which == 2};
    @(negedge clk);
    {saw, daw, cw} = 3'h0;
  endtask
  task automatic go(input logic [31:0] s, input logic [31:0] d, input logic [23:0] c);
    check({done, rd_err, wr_err, cfg_err}, 4'h0);
    load(s, 0);
    load(d, 1);
    load({8'h00, c}, 2);
    {n_rd, n_wr, n_drop, n_brd, prio_seen} = 0;
    if (!ext) begin
      @(negedge clk);
      st = 1'h1;
      @(negedge clk);
      st = 1'h0;
    end
  endtask
  task automatic wait_done(input int lim);
    for (int i = 0; i < lim && done !== 1'h1; i++) @(negedge clk);
    check(done, 1'h1);
    @(negedge clk);
  endtask
  task automatic clear;
    @(negedge clk);
    dw = 1'h1;
    @(negedge clk);
    dw = 1'h0;
    @(negedge clk);
    check({done, irq, rd_err, wr_err, cfg_err}, 5'h0);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int k;
    int e;
    rows = '{'{SZ_LONG, SZ_LONG, 1'h1, 1'h1, 24'h8, 8'h2, 8'h2},
             '{SZ_BYTE, SZ_BYTE, 1'h1, 1'h0, 24'h3, 8'h3, 8'h3},
             '{SZ_WORD, SZ_WORD, 1'h0, 1'h1, 24'h4, 8'h2, 8'h2},
             '{SZ_LINE, SZ_LINE, 1'h1, 1'h1, 24'h20, 8'h2, 8'h2},
             '{SZ_LONG, SZ_BYTE, 1'h1, 1'h1, 24'h8, 8'h2, 8'h8},
             '{SZ_BYTE, SZ_WORD, 1'h0, 1'h0, 24'h6, 8'h6, 8'h3}};
    repeat (5) @(negedge clk);
    nrst = 1'h1;
    @(negedge clk);
    check({busy, done, bus_req, rw, irq}, 5'h2);
    check(count, 24'h0);
    ie = 1'h1;
    for (k = 0; k < 6; k++) begin
      {ss, ds, si, di, lat} = {rows[k][45:40], k[1:0]};
      go(32'h1000, 32'h2000, rows[k].cnt);
      wait_done(2000);
      check(src_a, 32'h1000 + (si ? {8'h00, rows[k].cnt} : 32'h0));
      check(dst_a, 32'h2000 + (di ? {8'h00, rows[k].cnt} : 32'h0));
      check(count, 24'h0);
      check({n_rd[7:0], n_wr[7:0]}, {rows[k].rd, rows[k].wr});
      check(irq, 1'h1);
      clear();
    end
    {lat, sa, ss, ds, si, di} = {2'h0, 1'h1, SZ_BYTE, SZ_BYTE, 1'h1, 1'h0};
    for (e = 0; e < 2; e++) begin
      srd = (e == 0);
      go(32'h1000, 32'h2000, 24'h4);
      wait_done(500);
      check({n_rd[7:0], n_wr[7:0]}, (e == 0) ? {8'h4, 8'h0} : {8'h0, 8'h4});
      check(src_a, 32'h1004);
      check(dst_a, 32'h2000);
      clear();
    end
    {sa, ss, ds, di} = {1'h0, SZ_LONG, SZ_LONG, 1'h1};
    go(32'h1001, 32'h2000, 24'h8);
    wait_done(200);
    check({cfg_err, n_rd[7:0], n_wr[7:0]}, 17'h10000);
    clear();
    for (e = 0; e < 2; e++) begin
      {erd, ewr} = {e == 0, e == 1};
      go(32'h1000, 32'h2000, 24'h8);
      for (k = 0; k < 200 && (rd_err | wr_err) !== 1'h1; k++) @(negedge clk);
      repeat (3) @(negedge clk);
      check({rd_err, wr_err}, {e == 0, e == 1});
      check({busy, n_rd[7:0], n_wr[7:0]}, {1'h0, 8'h1, e[7:0]});
      clear();
    end
    {erd, ewr, ext, cs} = 4'h3;
    go(32'h1000, 32'h2000, 24'h8);
    repeat (10) @(negedge clk);
    check({bus_req, busy}, 2'h0);
    for (e = 0; e < 2; e++) begin
      xreq = 1'h1;
      repeat (3) @(negedge clk);
      xreq = 1'h0;
      repeat (40) @(negedge clk);
      check({count, done}, (e == 0) ? {24'h4, 1'h0} : {24'h0, 1'h1});
      check(n_ext, (e + 1) * 2);
    end
    clear();
    // continuous mode: the requester keeps its line up until done shows
    cs = 1'h0;
    go(32'h1000, 32'h2000, 24'h8);
    xreq = 1'h1;
    wait_done(200);
    xreq = 1'h0;
    check({n_rd[7:0], n_wr[7:0], n_ext[7:0]}, 24'h020208);
    check(count, 24'h0);
    clear();
    // single-address byte cycle-steal: five edges of request give one access
    {cs, sa, ss, srd} = {1'h1, 1'h1, SZ_BYTE, 1'h1};
    go(32'h1000, 32'h2000, 24'h4);
    xreq = 1'h1;
    repeat (5) @(negedge clk);
    xreq = 1'h0;
    repeat (30) @(negedge clk);
    check({count[15:0], n_rd[7:0], n_wr[7:0]}, {16'h3, 8'h1, 8'h0});
    {sa, ss, srd} = {1'h0, SZ_LONG, 1'h0};
    {ext, cs, aa, si, ds} = {3'h1, 1'h0, SZ_BYTE};
    go(32'h1, 32'h2000, 24'hf0);
    wait_done(4000);
    check(src_a, 32'hf1);
    check(dst_a, 32'h20f0);
    check({cfg_err, n_rd[7:0], n_wr[7:0], n_brd[7:0]}, {1'h0, 8'd62, 8'hf0, 8'h2});
    clear();
    {aa, si, ds} = {2'h1, SZ_LONG};
    for (e = 0; e < 2; e++) begin
      bw = e[2:0];
      go(32'h1000, 32'h4000, 24'h400);
      wait_done(8000);
      check({n_drop[7:0], prio_seen}, {e[7:0], e == 0});
      clear();
    end
    results();
  end
  // the longest case needs a few thousand cycles; this leaves ample margin
  initial begin
    #400000;
    fail_count++;
    results();
  end
endmodule
